// [rtl/option_link_fault_watchdog.sv]
// module: option board link fault and host timeout reaction logic
// Functional notes
// - option error code 00 trips at once
// - option error code 01 keeps running
// - silence while running reaching timeout applies action
// - timeout codes trip, decel-trip, ignore, coast, decel
`timescale 1ns/10ps
`default_nettype none
module option_link_fault_watchdog
  import link_fault_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire settings_type settings,
  input wire logic running,
  input wire logic stopped,
  input wire logic option_link_error,
  input wire logic host_msg_valid,
  input wire logic fault_reset,
  output reaction_type reaction,
  output logic timeout_flag
);

  typedef enum logic [1:0] {
    IDLE,
    DECEL_TRIP,
    TRIPPED
  } phase_type;

  typedef struct packed {
    phase_type phase;
    reaction_type react;
    logic tmo;
  } wd_state_type;

  wd_state_type s_q;
  wd_state_type s_d;
  logic expired;

  // ==========================================
  // silence timer
  // the timer owns the silence count; this level only reacts to its expiry
  host_silence_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .running(running),
    .host_msg_valid(host_msg_valid),
    .period(settings.host_comm_timeout_period),
    .expired(expired)
  );

  // ==========================================
  // reaction sequencer
  // - the timeout flag is sticky; when expiry and fault reset meet, expiry wins
  // - an option error trip outranks a timeout in the same cycle
  // - decel-then-trip waits in a phase of its own until standstill is reported
  // - coast and plain decel requests are not latched: they stand only while
  //   the silence persists, so a host that comes back lifts them
  // - option errors are not looked at outside idle; a reaction already stands
  always_comb begin
    s_d = s_q;
    if (expired) begin
      s_d.tmo = 1'b1;
    end else if (fault_reset) begin
      s_d.tmo = 1'b0;
    end
    case (s_q.phase)
      IDLE: begin
        s_d.react = '0;
        if (option_link_error && settings.option_error_action_sel == OPT_ERR_TRIP) begin
          s_d.phase = TRIPPED;
          s_d.react.trip = 1'b1;
        end else if (expired) begin
          case (settings.host_timeout_action_sel)
            TMO_TRIP: begin
              s_d.phase = TRIPPED;
              s_d.react.trip = 1'b1;
            end
            TMO_DECEL_TRIP: begin
              s_d.phase = DECEL_TRIP;
              s_d.react.decel_stop = 1'b1;
            end
            TMO_COAST: s_d.react.coast_stop = 1'b1;
            TMO_DECEL: s_d.react.decel_stop = 1'b1;
            default: s_d.react = '0; // ignore, and unused codes
          endcase
        end
        // option error with continue: nothing changes
      end
      DECEL_TRIP: begin
        if (stopped) begin
          s_d.phase = TRIPPED;
          s_d.react.decel_stop = 1'b0;
          s_d.react.trip = 1'b1;
        end
      end
      TRIPPED: begin
        if (fault_reset) begin
          s_d.phase = IDLE;
          s_d.react = '0;
        end
      end
      default: s_d.phase = IDLE;
    endcase
  end

  // ==========================================
  // state register
  // one register for the whole state; reset clears every output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from the state register
  assign reaction = s_q.react;
  assign timeout_flag = s_q.tmo;

  // ==========================================
  // checks: option error reaction and trip state
  a_opt_err_trip: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && option_link_error && settings.option_error_action_sel == OPT_ERR_TRIP)
    |=> reaction.trip)
    else $error("option error did not trip");
  a_trip_holds: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == TRIPPED && !fault_reset)
    |=> reaction.trip)
    else $error("trip dropped before fault reset");
  a_trip_release: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == TRIPPED && fault_reset)
    |=> !reaction.trip)
    else $error("trip held after fault reset");
  a_opt_err_cont: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && !expired && option_link_error
     && settings.option_error_action_sel == OPT_ERR_CONTINUE)
    |=> reaction == '0)
    else $error("continue setting changed operation");

  // ==========================================
  // checks: host timeout reaction per action code
  a_tmo_trip: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && expired && !option_link_error
     && settings.host_timeout_action_sel == TMO_TRIP)
    |=> reaction.trip)
    else $error("timeout trip missing");
  a_tmo_decel_trip: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && expired && !option_link_error
     && settings.host_timeout_action_sel == TMO_DECEL_TRIP)
    |=> reaction.decel_stop && !reaction.trip)
    else $error("decel before trip missing");
  a_decel_holds: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == DECEL_TRIP && !stopped)
    |=> reaction.decel_stop && !reaction.trip)
    else $error("decel dropped before standstill");
  a_decel_then_trip: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == DECEL_TRIP && stopped)
    |=> reaction.trip && !reaction.decel_stop)
    else $error("trip after decel missing");
  a_tmo_ignore: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && expired && !option_link_error
     && settings.host_timeout_action_sel == TMO_IGNORE)
    |=> reaction == '0)
    else $error("ignored timeout reacted");
  a_tmo_coast: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && expired && !option_link_error
     && settings.host_timeout_action_sel == TMO_COAST)
    |=> reaction.coast_stop && !reaction.trip)
    else $error("coast action wrong");
  a_tmo_decel: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && expired && !option_link_error
     && settings.host_timeout_action_sel == TMO_DECEL)
    |=> reaction.decel_stop && !reaction.trip && !reaction.coast_stop)
    else $error("decel action wrong");
  a_unused_codes: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && expired && !option_link_error
     && settings.host_timeout_action_sel > TMO_DECEL)
    |=> reaction == '0)
    else $error("unused timeout code reacted");
  a_stop_kinds: assert property (@(posedge clk) disable iff (!rstn)
    (reaction.trip || reaction.decel_stop) |-> !reaction.coast_stop)
    else $error("coast requested beside another reaction");

  // ==========================================
  // checks: silence timing and timeout flag
  a_tmo_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    expired
    |=> timeout_flag)
    else $error("timeout flag not set");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (timeout_flag && !fault_reset)
    |=> timeout_flag)
    else $error("timeout flag dropped by itself");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
    (!expired && fault_reset)
    |=> !timeout_flag)
    else $error("timeout flag not cleared");
  a_flag_needs_expiry: assert property (@(posedge clk) disable iff (!rstn)
    (!timeout_flag && !expired)
    |=> !timeout_flag)
    else $error("timeout flag set without expiry");
  a_quiet_idle: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == IDLE && !expired && !option_link_error)
    |=> reaction == '0)
    else $error("reaction without a cause");
  a_stop_no_expire: assert property (@(posedge clk) disable iff (!rstn)
    (!running)[*2]
    |=> !expired)
    else $error("expiry while stopped");
  a_reset_quiet: assert property (@(posedge clk) $rose(rstn) |-> reaction == '0 && !timeout_flag)
    else $error("outputs not clear after reset");

  // ==========================================
  // scenarios worth seeing
  c_opt_trip: cover property (@(posedge clk) disable iff (!rstn) option_link_error ##1 reaction.trip);
  c_decel_trip: cover property (@(posedge clk) disable iff (!rstn) s_q.phase == DECEL_TRIP ##[1:20] reaction.trip);
  c_expire: cover property (@(posedge clk) disable iff (!rstn) expired);
  c_reset: cover property (@(posedge clk) disable iff (!rstn) s_q.phase == TRIPPED ##1 s_q.phase == IDLE);
  c_coast: cover property (@(posedge clk) disable iff (!rstn) reaction.coast_stop);

endmodule
`default_nettype wire

// [rtl/link_fault_pkg.sv]
// package: constants and carrier types for the option link fault watchdog
package link_fault_pkg;

  // ==========================================
  // option error action codes
  localparam logic [1:0] OPT_ERR_TRIP = 2'h0;
  localparam logic [1:0] OPT_ERR_CONTINUE = 2'h1;

  // ==========================================
  // host timeout action codes
  localparam logic [2:0] TMO_TRIP = 3'h0;
  localparam logic [2:0] TMO_DECEL_TRIP = 3'h1;
  localparam logic [2:0] TMO_IGNORE = 3'h2;
  localparam logic [2:0] TMO_COAST = 3'h3;
  localparam logic [2:0] TMO_DECEL = 3'h4;

  // ==========================================
  // timing: period is set in units of 10 ms (0 to 9999 = 0.00 to 99.99 s)
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 18;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int PERIOD_W = 14;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 14'h270f;
  localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 14'h0000;
  localparam logic [TICK_W-1:0] TICK_ZERO = 18'h00000;

  // ==========================================
  // settings carried from the drive configuration
  typedef struct packed {
    logic [1:0] option_error_action_sel;
    logic [PERIOD_W-1:0] host_comm_timeout_period;
    logic [2:0] host_timeout_action_sel;
  } settings_type;

  // commands issued to the drive sequencer
  typedef struct packed {
    logic trip;
    logic decel_stop;
    logic coast_stop;
  } reaction_type;

endpackage

// [rtl/host_silence_timer.sv]
// module: timer of host silence while the drive runs
`timescale 1ns/10ps
`default_nettype none
module host_silence_timer
  import link_fault_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic running,
  input wire logic host_msg_valid,
  input wire logic [PERIOD_W-1:0] period,
  output logic expired
);

  typedef struct packed {
    logic [TICK_W-1:0] tick;
    logic [PERIOD_W-1:0] units;
    logic expired;
  } timer_state_type;

  timer_state_type s_q;
  timer_state_type s_d;

  // ==========================================
  // count 10 ms units of silence; restart on message, hold clear when stopped
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (!running || host_msg_valid) begin
      s_d.tick = TICK_ZERO;
      s_d.units = PERIOD_ZERO;
    end else if (s_q.units >= period) begin
      s_d.expired = 1'b1;
    end else if (s_q.tick == TICK_LAST) begin
      s_d.tick = TICK_ZERO;
      s_d.units = s_q.units + 14'h0001;
    end else begin
      s_d.tick = s_q.tick + 18'h00001;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

  // ==========================================
  // checks
  a_stop_clears: assert property (@(posedge clk) disable iff (!rstn)
    !running |=> !expired) else $error("timer expired while stopped");
  a_msg_restarts: assert property (@(posedge clk) disable iff (!rstn)
    host_msg_valid |=> !expired) else $error("timer expired after message");
  a_expire_at_period: assert property (@(posedge clk) disable iff (!rstn)
    (running && !host_msg_valid && s_q.units >= period) |=> expired)
    else $error("silence reached the period without expiry");

endmodule
`default_nettype wire

// [verification/host_link_model.sv]
// partner: host controller traffic and option board link model
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  input wire logic clk,
  output logic host_msg_valid,
  output logic option_link_error
);
  // ==========================================
  // link idle levels
  initial begin
    host_msg_valid = 1'b0;
    option_link_error = 1'b0;
  end
  // n back-to-back host messages, one per cycle, from this falling edge on
  task automatic send_msgs(input int n);
    host_msg_valid = 1'b1;
    repeat (n) @(negedge clk);
    host_msg_valid = 1'b0;
  endtask
  // board data exchange fault held for n cycles
  task automatic board_fault(input int n);
    @(negedge clk) option_link_error = 1'b1;
    repeat (n) @(negedge clk);
    option_link_error = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/test_option_link_fault_watchdog.sv]
// testbench: option link fault and host timeout scenarios
`timescale 1ns/10ps
`default_nettype none
module test_option_link_fault_watchdog import link_fault_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic running = 1'b0;
  logic stopped = 1'b1;
  logic fault_reset = 1'b0;
  settings_type settings = '0;
  wire logic host_msg_valid;
  wire logic option_link_error;
  reaction_type reaction;
  logic timeout_flag;
  int n_mismatch = 0;
  int checks_done = 0;
  // flag, trip, decel, coast after expiry, then after standstill
  logic [3:0] tmo_exp [5] = '{4'hc, 4'ha, 4'h8, 4'h9, 4'ha};
  logic [3:0] end_exp [5] = '{4'hc, 4'hc, 4'h8, 4'h8, 4'h8};
  // ==========================================
  // clock and instances
  always #20 clk = ~clk;
  option_link_fault_watchdog u_dut (.clk(clk), .rstn(rstn), .settings(settings), .running(running),
    .stopped(stopped), .option_link_error(option_link_error), .host_msg_valid(host_msg_valid),
    .fault_reset(fault_reset), .reaction(reaction), .timeout_flag(timeout_flag));
  host_link_model u_host (.clk(clk), .host_msg_valid(host_msg_valid), .option_link_error(option_link_error));
  // ==========================================
  // checking and closing
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  // bench drops running itself, a stop path apart from the board
  task automatic clear_fault();
    @(negedge clk) running = 1'b0;
    stopped = 1'b1;
    fault_reset = 1'b1;
    @(negedge clk) fault_reset = 1'b0;
  endtask
  // board fault reaction per option error code
  task automatic opt_error_case(input logic [1:0] code, input logic [3:0] exp);
    settings.option_error_action_sel = code;
    u_host.board_fault(1);
    repeat (2) @(negedge clk);
    chk("opt err", {timeout_flag, reaction}, exp);
    clear_fault();
  endtask
  // period zero: silence while stopped never expires, a message every cycle keeps it off
  task automatic quiet_case();
    repeat (10) @(negedge clk);
    chk("stopped", {timeout_flag, reaction}, 4'h0);
    running = 1'b1;
    stopped = 1'b0;
    u_host.send_msgs(10);
    running = 1'b0;
    stopped = 1'b1;
    chk("msg", {timeout_flag, reaction}, 4'h0);
    clear_fault();
  endtask
  // expiry with period zero, then standstill
  task automatic timeout_case(input logic [2:0] code, input logic [3:0] e1, input logic [3:0] e2);
    int i;
    settings.host_timeout_action_sel = code;
    @(negedge clk) running = 1'b1;
    stopped = 1'b0;
    for (i = 0; i < 20 && timeout_flag !== 1'b1; i++) @(negedge clk);
    if (i == 20) begin
      n_mismatch++;
      summarize();
    end
    @(negedge clk);
    chk("expiry", {timeout_flag, reaction}, e1);
    running = 1'b0;
    stopped = 1'b1;
    repeat (2) @(negedge clk);
    chk("standstill", {timeout_flag, reaction}, e2);
    clear_fault();
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk("reset", {timeout_flag, reaction}, 4'h0);
    opt_error_case(2'h0, 4'h4);
    opt_error_case(2'h1, 4'h0);
    quiet_case();
    for (int k = 0; k < 5; k++) timeout_case(3'(k), tmo_exp[k], end_exp[k]);
    timeout_case(3'h5, 4'h8, 4'h8);
    summarize();
  end
endmodule
`default_nettype wire
